// ### core/spc_host.sv
// Added by the designer: the placing of the registers and the APB register port.
module spc_host #(
  parameter int CONFIG_CLOCK_HALF = spc_pkg::CONFIG_CLOCK_HALF_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Interrupt
  output logic irq_out,
  // Link to the device
  spc_link_if.host link
);

  // Below four cycles the busy answer cannot cross back in time.
  if (CONFIG_CLOCK_HALF < 4 || CONFIG_CLOCK_HALF > 255)
  begin : g_param_check
    $error("spc_host: CONFIG_CLOCK_HALF out of range");
  end

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_PROG = 6'h02,
    H_WAIT_INIT = 6'h04,
    H_LOAD = 6'h08,
    H_DONE = 6'h10,
    H_ERROR = 6'h20
  } spc_host_state_e;

  spc_host_state_e state;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic init_s;
  logic done_s;
  logic busy_s;
  logic [2:0] prog_cnt;
  logic [7:0] half_cnt;
  logic present;
  logic consumed;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_set;
  logic access;
  logic complete;
  logic is_data;
  logic is_ctrl;
  logic mapped;
  logic locked;
  logic data_stall;
  logic bad;
  logic start;
  logic half_end;
  logic [31:0] rdata;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end
    else
    begin
      sync1 <= {link.init_line, link.done_line, link.busy};
      sync2 <= sync1;
    end
  end

  assign {init_s, done_s, busy_s} = sync2;
  assign access = psel_in && penable_in;
  assign complete = access && pready_out;
  assign is_data = paddr_in == spc_pkg::REG_DATA;
  assign is_ctrl = paddr_in == spc_pkg::REG_CTRL;
  assign mapped = is_data || is_ctrl || paddr_in == spc_pkg::REG_STATUS
                  || paddr_in == spc_pkg::REG_IRQ_STATUS || paddr_in == spc_pkg::REG_IRQ_MASK;
  assign locked = state inside {H_PROG, H_WAIT_INIT, H_LOAD};
  assign data_stall = pwrite_in && is_data && present && state == H_LOAD;
  assign bad = !mapped || (pwrite_in && is_data && state != H_LOAD)
               || (pwrite_in && is_ctrl && locked);
  assign start = complete && pwrite_in && is_ctrl && !locked && pwdata_in[spc_pkg::CTRL_START_BIT];
  assign half_end = half_cnt == 8'(CONFIG_CLOCK_HALF - 1);

  always_comb
  begin
    rdata = 32'h0;
    case (paddr_in)
      spc_pkg::REG_CTRL:
      begin
        rdata[spc_pkg::CTRL_MODE_LSB +: 3] = link.mode;
        rdata[spc_pkg::CTRL_PULLUP_DIS_BIT] = link.pullup_disable;
      end
      spc_pkg::REG_STATUS:
      begin
        rdata[spc_pkg::STAT_INIT_BIT] = init_s;
        rdata[spc_pkg::STAT_DONE_BIT] = done_s;
        rdata[spc_pkg::STAT_BUSY_BIT] = busy_s;
        rdata[spc_pkg::STAT_PENDING_BIT] = present;
        rdata[spc_pkg::STAT_STATE_LSB +: 6] = state;
      end
      spc_pkg::REG_IRQ_STATUS:
      begin
        rdata[spc_pkg::IRQ_W-1:0] = irq_status;
      end
      spc_pkg::REG_IRQ_MASK:
      begin
        rdata[spc_pkg::IRQ_W-1:0] = irq_mask;
      end
      default:
      begin
        rdata = 32'h0;
      end
    endcase
  end

  // The answer comes one cycle into the access phase, later for a data write while a byte is pending.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end
    else
    begin
      pready_out <= access && !pready_out && !data_stall;
      pslverr_out <= access && !pready_out && !data_stall && bad;
      prdata_out <= (access && !pready_out && !pwrite_in) ? rdata : 32'h0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      link.mode <= spc_pkg::CTRL_MODE_RESET;
      link.pullup_disable <= spc_pkg::CTRL_PULLUP_DIS_RESET;
      irq_mask <= spc_pkg::IRQ_MASK_RESET;
    end
    else if (complete && pwrite_in)
    begin
      if (is_ctrl && !locked)
      begin
        link.mode <= pwdata_in[spc_pkg::CTRL_MODE_LSB +: 3];
        link.pullup_disable <= pwdata_in[spc_pkg::CTRL_PULLUP_DIS_BIT];
      end
      if (paddr_in == spc_pkg::REG_IRQ_MASK)
      begin
        irq_mask <= pwdata_in[spc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= H_IDLE;
      prog_cnt <= 3'h0;
      link.program_request_n <= 1'b1;
      link.chip_select_n <= 1'b1;
      link.write_select_n <= 1'b1;
    end
    else
    begin
      case (state)
        H_IDLE, H_DONE, H_ERROR:
        begin
          if (start)
          begin
            state <= H_PROG;
            prog_cnt <= 3'h0;
            link.program_request_n <= 1'b0;
          end
        end
        H_PROG:
        begin
          if (prog_cnt != 3'(spc_pkg::PROG_LOW_CYCLES))
          begin
            prog_cnt <= prog_cnt + 3'h1;
          end
          else if (!init_s)
          begin
            state <= H_WAIT_INIT;
            link.program_request_n <= 1'b1;
          end
        end
        H_WAIT_INIT:
        begin
          if (init_s)
          begin
            state <= H_LOAD;
            link.chip_select_n <= 1'b0;
            link.write_select_n <= 1'b0;
          end
        end
        H_LOAD:
        begin
          if (done_s || !init_s)
          begin
            state <= done_s ? H_DONE : H_ERROR;
            link.chip_select_n <= 1'b1;
            link.write_select_n <= 1'b1;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // The clock runs only while a byte is presented and parks low otherwise.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      present <= 1'b0;
      consumed <= 1'b0;
      half_cnt <= 8'h0;
      link.config_clock <= 1'b0;
      link.data <= 8'h0;
    end
    else if (state != H_LOAD)
    begin
      present <= 1'b0;
      consumed <= 1'b0;
      half_cnt <= 8'h0;
      link.config_clock <= 1'b0;
    end
    else if (!present)
    begin
      half_cnt <= 8'h0;
      if (complete && pwrite_in && is_data)
      begin
        present <= 1'b1;
        link.data <= pwdata_in[7:0];
      end
    end
    else if (!half_end)
    begin
      half_cnt <= half_cnt + 8'h1;
    end
    else
    begin
      half_cnt <= 8'h0;
      link.config_clock <= !link.config_clock;
      if (!link.config_clock)
      begin
        // Busy is always honoured, which also covers rates under 50 MHz.
        consumed <= !busy_s;
      end
      else if (consumed)
      begin
        present <= 1'b0;
        consumed <= 1'b0;
      end
    end
  end

  always_comb
  begin
    irq_set = 3'h0;
    irq_set[spc_pkg::IRQ_READY_BIT] = state == H_WAIT_INIT && init_s;
    irq_set[spc_pkg::IRQ_DONE_BIT] = state == H_LOAD && done_s;
    irq_set[spc_pkg::IRQ_ERROR_BIT] = state == H_LOAD && !done_s && !init_s;
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      irq_status <= 3'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (complete && pwrite_in && paddr_in == spc_pkg::REG_IRQ_STATUS)
      begin
        irq_status <= (irq_status & ~pwdata_in[spc_pkg::IRQ_W-1:0]) | irq_set;
      end
      else
      begin
        irq_status <= irq_status | irq_set;
      end
      irq_out <= |(irq_status & irq_mask);
    end
  end

endmodule

// ### core/spc_pkg.sv
package spc_pkg;

  // Clock and link timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_LOW_MIN_NS = 300;
  localparam int PROG_LOW_CYCLES = (PROG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONFIG_CLOCK_HALF_DEFAULT = 4;

  // Device loading defaults.
  localparam int CLEAR_CYCLES_DEFAULT = 16;
  localparam int IMAGE_BYTES_DEFAULT = 16;
  localparam int BURST_BYTES_DEFAULT = 4;
  localparam logic [2:0] MODE_SLAVE_PARALLEL = 3'h6;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;

  // Host register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  // Control fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_PULLUP_DIS_BIT = 4;
  localparam logic [2:0] CTRL_MODE_RESET = 3'h6;
  localparam logic CTRL_PULLUP_DIS_RESET = 1'b0;

  // Status fields.
  localparam int STAT_INIT_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_PENDING_BIT = 3;
  localparam int STAT_STATE_LSB = 4;

  // Interrupt fields.
  localparam int IRQ_W = 3;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_ERROR_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

// ### core/spc_link_if.sv
interface spc_link_if;
  logic program_request_n;
  logic chip_select_n;
  logic write_select_n;
  logic config_clock;
  logic [7:0] data;
  logic [2:0] mode;
  logic pullup_disable;
  logic busy;
  logic chain_select_out_n;
  logic init_o;
  logic init_oe;
  logic done_o;
  logic done_oe;
  logic init_line;
  logic done_line;

  // Both status lines are open drain with a board pull-up.
  assign init_line = (init_oe && !init_o) ? 1'b0 : 1'b1;
  assign done_line = (done_oe && !done_o) ? 1'b0 : 1'b1;

  modport dev (
    input program_request_n, chip_select_n, write_select_n, config_clock, data,
    input mode, pullup_disable, init_line, done_line,
    output busy, chain_select_out_n, init_o, init_oe, done_o, done_oe
  );

  modport host (
    output program_request_n, chip_select_n, write_select_n, config_clock, data,
    output mode, pullup_disable,
    input busy, chain_select_out_n, init_line, done_line
  );
endinterface

// ### core/spc_device.sv
module spc_device #(
  parameter int CLEAR_CYCLES = spc_pkg::CLEAR_CYCLES_DEFAULT,
  parameter int IMAGE_BYTES = spc_pkg::IMAGE_BYTES_DEFAULT,
  parameter int BURST_BYTES = spc_pkg::BURST_BYTES_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link to the download host
  spc_link_if.dev link,
  // User side
  input wire logic keep_port_in,
  output logic pullups_on_out,
  output logic [7:0] config_byte_out,
  output logic config_byte_valid_out,
  output logic configured_out,
  output logic user_pins_free_out
);

  // The counters are 16 bits wide, so larger counts are refused when the design is built.
  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65535 || IMAGE_BYTES < 2 || IMAGE_BYTES > 65535
      || BURST_BYTES < 1 || BURST_BYTES > 65535)
  begin : g_param_check
    $error("spc_device: parameter out of range");
  end

  typedef enum logic [6:0] {
    D_WAIT = 7'h01,
    D_CLEAR = 7'h02,
    D_RELEASE = 7'h04,
    D_LOAD = 7'h08,
    D_DONE = 7'h10,
    D_OTHER = 7'h20,
    D_ERROR = 7'h40
  } spc_dev_state_e;

  localparam int SW = 17;

  function automatic logic [7:0] spc_crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ spc_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic config_clock_prev;
  logic prog_n_s;
  logic cs_n_s;
  logic ws_n_s;
  logic config_clock_s;
  logic [7:0] data_s;
  logic [2:0] mode_s;
  logic pud_s;
  logic init_s;
  logic config_clock_rise;
  logic write_strobe;
  spc_dev_state_e state;
  spc_dev_state_e next_state;
  logic [2:0] prog_cnt;
  logic prog_qualified;
  logic [15:0] clear_cnt;
  logic [15:0] byte_cnt;
  logic [15:0] burst_cnt;
  logic [7:0] crc;
  logic [7:0] next_crc;
  logic take_byte;
  logic last_byte;

  // Every pin from the host crosses into this clock through two flip-flops.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
      config_clock_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {link.program_request_n, link.chip_select_n, link.write_select_n,
                link.config_clock, link.data, link.mode, link.pullup_disable, link.init_line};
      sync2 <= sync1;
      config_clock_prev <= config_clock_s;
    end
  end

  assign {prog_n_s, cs_n_s, ws_n_s, config_clock_s, data_s, mode_s, pud_s, init_s} = sync2;
  assign config_clock_rise = config_clock_s && !config_clock_prev;
  assign write_strobe = config_clock_rise && !cs_n_s && !ws_n_s;
  assign take_byte = write_strobe && !link.busy;
  assign last_byte = byte_cnt == 16'(IMAGE_BYTES - 1);
  assign next_crc = spc_crc8(crc, data_s);
  assign prog_qualified = prog_cnt == 3'(spc_pkg::PROG_LOW_CYCLES);

  // Short glitches on the program request are filtered out by this count.
  always_ff @(posedge clk_in)
  begin
    if (srst_in || prog_n_s)
    begin
      prog_cnt <= '0;
    end
    else if (!prog_qualified)
    begin
      prog_cnt <= prog_cnt + 3'h1;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      D_WAIT:
      begin
        if (prog_n_s)
        begin
          next_state = D_CLEAR;
        end
      end
      D_CLEAR:
      begin
        if (clear_cnt == 16'(CLEAR_CYCLES - 1))
        begin
          next_state = D_RELEASE;
        end
      end
      D_RELEASE:
      begin
        // An outside party holding init low delays the mode sampling.
        if (init_s)
        begin
          next_state = (mode_s == spc_pkg::MODE_SLAVE_PARALLEL) ? D_LOAD : D_OTHER;
        end
      end
      D_LOAD:
      begin
        if (take_byte && last_byte)
        begin
          next_state = (next_crc == 8'h00) ? D_DONE : D_ERROR;
        end
      end
      D_DONE, D_OTHER, D_ERROR:
      begin
        next_state = state;
      end
      default:
      begin
        next_state = D_WAIT;
      end
    endcase
    if (prog_qualified)
    begin
      next_state = D_WAIT;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= D_WAIT;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in || state != D_CLEAR)
    begin
      clear_cnt <= '0;
    end
    else
    begin
      clear_cnt <= clear_cnt + 16'h1;
    end
  end

  // Byte loading, running check value and flow control.
  always_ff @(posedge clk_in)
  begin
    if (srst_in || state != D_LOAD)
    begin
      byte_cnt <= '0;
      burst_cnt <= '0;
      crc <= spc_pkg::CRC_SEED;
      link.busy <= 1'b0;
    end
    else if (write_strobe && link.busy)
    begin
      link.busy <= 1'b0;
    end
    else if (take_byte)
    begin
      byte_cnt <= byte_cnt + 16'h1;
      crc <= next_crc;
      if (burst_cnt == 16'(BURST_BYTES - 1))
      begin
        burst_cnt <= '0;
        // The refill pause costs one clock edge after each burst, except a burst that ends on the last byte.
        link.busy <= !last_byte;
      end
      else
      begin
        burst_cnt <= burst_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      config_byte_out <= '0;
      config_byte_valid_out <= 1'b0;
    end
    else
    begin
      config_byte_valid_out <= 1'b0;
      if ((state == D_LOAD && take_byte) || (state == D_DONE && keep_port_in && write_strobe))
      begin
        config_byte_out <= data_s;
        config_byte_valid_out <= 1'b1;
      end
    end
  end

  // Pin outputs follow the next state so they settle with it.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      link.init_o <= 1'b0;
      link.init_oe <= 1'b1;
      link.done_o <= 1'b0;
      link.done_oe <= 1'b1;
      link.chain_select_out_n <= 1'b1;
      pullups_on_out <= 1'b0;
      configured_out <= 1'b0;
      user_pins_free_out <= 1'b0;
    end
    else
    begin
      link.init_o <= 1'b0;
      link.init_oe <= next_state inside {D_WAIT, D_CLEAR, D_ERROR};
      link.done_o <= 1'b0;
      link.done_oe <= next_state != D_DONE;
      link.chain_select_out_n <= !(next_state == D_DONE && !cs_n_s);
      pullups_on_out <= next_state != D_DONE && !pud_s;
      configured_out <= next_state == D_DONE;
      user_pins_free_out <= next_state == D_DONE && !keep_port_in;
    end
  end

endmodule

// ### testbench/spc_link_assertions.sv
module spc_link_assertions (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link signals
  input wire logic program_request_n,
  input wire logic chip_select_n,
  input wire logic write_select_n,
  input wire logic config_clock,
  input wire logic [7:0] data,
  input wire logic [2:0] mode,
  input wire logic pullup_disable,
  input wire logic busy,
  input wire logic chain_select_out_n,
  input wire logic init_line,
  input wire logic done_line
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  chk_prog_drops_done: assert property (
    $rose(program_request_n) |-> !done_line && !init_line)
    else $error("program release with done or init still high");
  chk_clear_holds_init: assert property (
    $rose(program_request_n) |=> (!init_line) [*8])
    else $error("init released too early after program");
  chk_mode_at_init: assert property (
    $rose(init_line) |-> mode == spc_pkg::MODE_SLAVE_PARALLEL && $stable(mode))
    else $error("mode pins wrong when init rose");
  chk_capture_stable: assert property (
    config_clock |-> $stable(data))
    else $error("data moved while config clock high");
  chk_busy_when_loading: assert property (
    $rose(busy) |-> init_line && !done_line)
    else $error("busy raised outside loading");
  chk_busy_selects: assert property (
    busy |-> !chip_select_n && !write_select_n)
    else $error("selects high while busy");
  chk_pullup_frozen: assert property (
    init_line && !done_line |-> $stable(pullup_disable))
    else $error("pull-up select moved while loading");
  chk_done_stands: assert property (
    done_line && program_request_n |=> done_line)
    else $error("done dropped without program request");
  chk_done_clean: assert property (
    $rose(done_line) |-> init_line && !busy)
    else $error("done rose with init low or busy");
  chk_crc_error_hold: assert property (
    $fell(init_line) && program_request_n |-> !done_line ##1 (!init_line) [*8])
    else $error("error indication not held");
  chk_chain_after_done: assert property (
    $fell(chain_select_out_n) |-> done_line)
    else $error("chain select asserted before done");
endmodule

// ### testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NB = spc_pkg::IMAGE_BYTES_DEFAULT;
  logic clk_in;
  logic srst_in;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic keep_port;
  logic pullups_on;
  logic [7:0] cfg_byte;
  logic cfg_valid;
  logic configured;
  logic pins_free;
  logic [31:0] rd;
  logic err;
  logic [7:0] exp_q[$];
  int fails;
  int comparisons;
  int seed;

  spc_link_if link();

  spc_host u_spc_host (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
    .link(link));

  spc_device u_spc_device (.clk_in(clk_in), .srst_in(srst_in), .link(link),
    .keep_port_in(keep_port), .pullups_on_out(pullups_on), .config_byte_out(cfg_byte),
    .config_byte_valid_out(cfg_valid), .configured_out(configured),
    .user_pins_free_out(pins_free));

  spc_link_assertions u_spc_link_assertions (.clk_in(clk_in), .srst_in(srst_in),
    .program_request_n(link.program_request_n), .chip_select_n(link.chip_select_n),
    .write_select_n(link.write_select_n), .config_clock(link.config_clock),
    .data(link.data), .mode(link.mode), .pullup_disable(link.pullup_disable),
    .busy(link.busy), .chain_select_out_n(link.chain_select_out_n),
    .init_line(link.init_line), .done_line(link.done_line));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic stop_test();
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so psel is never set twice at once.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in iff pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wait_status(input int bit_no, input logic val);
    repeat (400)
    begin
      apb(1'b0, spc_pkg::REG_STATUS, 32'h0);
      if (rd[bit_no] === val)
        break;
    end
    check(32'(rd[bit_no]), 32'(val), "status wait");
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int b = 0; b < 8; b++)
      r = r[7] ? ((r << 1) ^ spc_pkg::CRC_POLY) : (r << 1);
    return r;
  endfunction

  // A bad image flips the low bit of the check byte, so the residue cannot be zero.
  task automatic load(input logic bad);
    logic [7:0] crc;
    logic [7:0] b;
    crc = spc_pkg::CRC_SEED;
    for (int i = 0; i < NB; i++)
    begin
      b = (i == NB - 1) ? (crc ^ {7'h0, bad}) : 8'($random(seed));
      crc = crc8(crc, b);
      exp_q.push_back(b);
      apb(1'b1, spc_pkg::REG_DATA, {24'($random(seed)), b});
      check(32'(err), 32'h0, "data write refused");
    end
  endtask

  task automatic run(input logic [31:0] ctrl, input logic bad);
    logic [31:0] ev;
    ev = 32'({bad, ~bad, 1'b1});
    apb(1'b1, spc_pkg::REG_CTRL, ctrl);
    wait_status(spc_pkg::STAT_STATE_LSB + 3, 1'b1);
    check(32'(pullups_on), 32'(!ctrl[4]), "pull-ups while loading");
    apb(1'b1, spc_pkg::REG_CTRL, ctrl ^ 32'h10);
    check(32'(err), 32'h1, "control write in load");
    load(bad);
    wait_status(bad ? spc_pkg::STAT_INIT_BIT : spc_pkg::STAT_DONE_BIT, ~bad);
    check(32'(configured), 32'(!bad), "configured");
    check(32'(pullups_on), 32'(bad && !ctrl[4]), "pull-ups after load");
    check(32'(pins_free), 32'(!bad && !keep_port), "user pins");
    check(32'(exp_q.size()), 32'h0, "bytes missing");
    apb(1'b0, spc_pkg::REG_IRQ_STATUS, 32'h0);
    check(rd, ev, "event status");
    check(32'(irq), 32'h1, "irq raised");
    apb(1'b1, spc_pkg::REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_in);
    check(32'(irq), 32'h0, "irq masked");
    apb(1'b1, spc_pkg::REG_IRQ_MASK, 32'h7);
    apb(1'b1, spc_pkg::REG_IRQ_STATUS, ev);
    apb(1'b0, spc_pkg::REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h0, "event cleared");
    check(32'(irq), 32'h0, "irq cleared");
  endtask

  always @(posedge clk_in)
    if (cfg_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'(cfg_byte), 32'hffff_ffff, "unexpected byte");
      else
        check(32'(cfg_byte), 32'(exp_q.pop_front()), "config byte");
    end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    stop_test();
  end

  initial
  begin
    seed = 32'hb5b8;
    fails = 0;
    comparisons = 0;
    srst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    keep_port = 1'b0;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    apb(1'b1, spc_pkg::REG_IRQ_MASK, 32'h7);
    apb(1'b0, spc_pkg::REG_IRQ_MASK, 32'h0);
    check(rd, 32'h7, "mask readback");
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, spc_pkg::REG_DATA, 32'h5a);
    check({31'h0, err}, 32'h1, "data outside load");
    run(32'h0d, 1'b0);
    run(32'h1d, 1'b1);
    keep_port <= 1'b1;
    run(32'h1d, 1'b0);
    stop_test();
  end
endmodule
